// ===== pts_sequencer.sv
// preempt timing sequencer with wishbone register slave
`timescale 1ns/1ps

module pts_sequencer #(
  parameter int TICK_CYCLES = pts_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [pts_pkg::NUM_CHANNELS-1:0] callInN,
  input wire pts_pkg::pts_phase_t phase,
  output pts_pkg::pts_ctl_t ctl,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // ********************************************************************
  // call input synchronisers
  // ********************************************************************
  logic [pts_pkg::NUM_CHANNELS-1:0] callMeta;
  logic [pts_pkg::NUM_CHANNELS-1:0] callSync;

  genvar gi;
  generate
    for (gi = 0; gi < pts_pkg::NUM_CHANNELS; gi++)
    begin : g_sync
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          callMeta[gi] <= 1'b0;
          callSync[gi] <= 1'b0;
        end
        else
        begin
          callMeta[gi] <= ~callInN[gi];
          callSync[gi] <= callMeta[gi];
        end
      end
    end
  endgenerate

  // ********************************************************************
  // one second tick
  // ********************************************************************
  logic [24:0] tickCnt;
  logic [24:0] next_tickCnt;
  logic tick;
  logic next_tick;

  always_comb
  begin
    next_tick = 1'b0;
    next_tickCnt = tickCnt + 25'h0000001;
    if (tickCnt == 25'(TICK_CYCLES - 1))
    begin
      next_tickCnt = 25'h0000000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tickCnt <= 25'h0000000;
      tick <= 1'b0;
    end
    else
    begin
      tickCnt <= next_tickCnt;
      tick <= next_tick;
    end
  end

  // ********************************************************************
  // register slave
  // ********************************************************************
  pts_pkg::pts_cfg_t cfg;
  pts_pkg::pts_cfg_t next_cfg;
  logic [31:0] next_datOut;
  logic next_ack;
  logic [31:0] wordOld;
  logic [31:0] wordNew;
  pts_pkg::pts_state_t state;
  logic callRaw;
  logic invalid;
  logic [13:0] durCnt;
  logic [7:0] ivlCnt;

  function automatic logic [31:0] pts_merge(input logic [31:0] oldW,
    input logic [31:0] newW, input logic [3:0] sel);
    logic [31:0] res;
    res = oldW;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[8*b +: 8] = newW[8*b +: 8];
      end
    end
    return res;
  endfunction : pts_merge

  function automatic logic [7:0] pts_floor(input logic [7:0] v);
    return (v < pts_pkg::DWELL_FLOOR) ? pts_pkg::DWELL_FLOOR : v;
  endfunction : pts_floor

  always_comb
  begin
    next_cfg = cfg;
    next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    next_datOut = wb_dat_o;
    wordOld = 32'h00000000;
    unique case (wb_adr_i)
      pts_pkg::ADDR_CTRL:
      begin
        wordOld[pts_pkg::CTRL_HOLD_BIT] = cfg.callHold;
        wordOld[pts_pkg::CTRL_SEL_LSB +: 4] = cfg.chanSel;
      end
      pts_pkg::ADDR_DELAY: wordOld[9:0] = cfg.delay;
      pts_pkg::ADDR_DURATION: wordOld[13:0] = cfg.minCallDuration;
      pts_pkg::ADDR_PRESENCE: wordOld[13:0] = cfg.maxCallPresence;
      pts_pkg::ADDR_PROTECT:
        wordOld = {cfg.trackGreenTime, cfg.protectedPedClearanceTime,
                   cfg.protectedWalkTime, cfg.protectedGreenTime};
      pts_pkg::ADDR_DWELL:
        wordOld[15:0] = {cfg.firstDwellTime, cfg.minDwellTime};
      pts_pkg::ADDR_STATUS:
      begin
        wordOld[5:0] = state;
        wordOld[pts_pkg::STAT_RAW_BIT] = callRaw;
        wordOld[pts_pkg::STAT_VALID_BIT] = callRaw & ~invalid;
        wordOld[pts_pkg::STAT_INVALID_BIT] = invalid;
      end
      pts_pkg::ADDR_TIMERS:
      begin
        wordOld[13:0] = durCnt;
        wordOld[pts_pkg::TIMERS_IVL_LSB +: 8] = ivlCnt;
      end
      default: wordOld = 32'h00000000;
    endcase
    wordNew = pts_merge(wordOld, wb_dat_i, wb_sel_i);
    if (next_ack)
    begin
      next_datOut = wb_we_i ? 32'h00000000 : wordOld;
    end
    // writes land on the edge where the master sees ack
    if (wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o)
    begin
      unique case (wb_adr_i)
        pts_pkg::ADDR_CTRL:
        begin
          next_cfg.callHold = wordNew[pts_pkg::CTRL_HOLD_BIT];
          next_cfg.chanSel = wordNew[pts_pkg::CTRL_SEL_LSB +: 4];
        end
        // delay capped at its printed range
        pts_pkg::ADDR_DELAY:
          next_cfg.delay = (wordNew[9:0] > pts_pkg::DELAY_MAX) ?
                           pts_pkg::DELAY_MAX : wordNew[9:0];
        pts_pkg::ADDR_DURATION:
          next_cfg.minCallDuration =
            (wordNew[13:0] > pts_pkg::DURATION_MAX) ?
            pts_pkg::DURATION_MAX : wordNew[13:0];
        pts_pkg::ADDR_PRESENCE:
          next_cfg.maxCallPresence =
            (wordNew[13:0] > pts_pkg::DURATION_MAX) ?
            pts_pkg::DURATION_MAX : wordNew[13:0];
        pts_pkg::ADDR_PROTECT:
        begin
          next_cfg.protectedGreenTime = wordNew[7:0];
          next_cfg.protectedWalkTime = wordNew[pts_pkg::PROT_WALK_LSB +: 8];
          next_cfg.protectedPedClearanceTime =
            wordNew[pts_pkg::PROT_PED_LSB +: 8];
          next_cfg.trackGreenTime = wordNew[pts_pkg::PROT_TRACK_LSB +: 8];
        end
        // dwell times never below one second
        pts_pkg::ADDR_DWELL:
        begin
          next_cfg.minDwellTime = pts_floor(wordNew[7:0]);
          next_cfg.firstDwellTime =
            pts_floor(wordNew[pts_pkg::DWELL_FIRST_LSB +: 8]);
        end
        default: next_cfg = cfg;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg <= '{callHold: 1'b0, chanSel: 4'h0,
               delay: pts_pkg::RST_DELAY,
               minCallDuration: pts_pkg::RST_DURATION,
               maxCallPresence: pts_pkg::RST_PRESENCE,
               protectedGreenTime: pts_pkg::RST_TIME8,
               protectedWalkTime: pts_pkg::RST_TIME8,
               protectedPedClearanceTime: pts_pkg::RST_TIME8,
               trackGreenTime: pts_pkg::RST_TIME8,
               minDwellTime: pts_pkg::RST_DWELL,
               firstDwellTime: pts_pkg::RST_DWELL};
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      cfg <= next_cfg;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_datOut;
    end
  end

  // ********************************************************************
  // call validation and preempt sequence
  // ********************************************************************
  pts_pkg::pts_state_t next_state;
  logic next_invalid;
  logic [13:0] presCnt;
  logic [13:0] next_presCnt;
  logic [9:0] dlyCnt;
  logic [9:0] next_dlyCnt;
  logic [13:0] next_durCnt;
  logic [7:0] next_ivlCnt;
  logic [7:0] grnCnt;
  logic [7:0] next_grnCnt;
  logic [7:0] wlkCnt;
  logic [7:0] next_wlkCnt;
  logic [7:0] pedCnt;
  logic [7:0] next_pedCnt;
  pts_pkg::pts_ctl_t next_ctl;
  logic validCall;
  logic grnOk;
  logic wlkOk;
  logic pedOk;
  logic postDelay;
  logic minsMet;

  // unused select codes read as no call
  assign callRaw = (cfg.chanSel < 4'(pts_pkg::NUM_CHANNELS)) ?
                   callSync[cfg.chanSel] : 1'b0;
  assign validCall = callRaw & ~invalid;
  assign postDelay = (state != pts_pkg::ST_IDLE) &&
                     (state != pts_pkg::ST_DELAY);
  assign minsMet = (ivlCnt == 8'h00) && (durCnt == 14'h0000);
  // lesser of preempt and phase minimum green
  assign grnOk = ~phase.greenActive | (grnCnt == 8'h00) |
                 phase.minGreenDone;
  // lesser of preempt and phase walk
  // an overlap walk is never held
  assign wlkOk = ~phase.walkActive | phase.walkFromOverlap |
                 (wlkCnt == 8'h00) | phase.walkDone;
  // lesser of preempt and phase clearance
  assign pedOk = ~phase.pedClearActive | (pedCnt == 8'h00) |
                 phase.pedClearDone;

  always_comb
  begin
    next_state = state;
    next_invalid = invalid;
    next_presCnt = presCnt;
    next_dlyCnt = dlyCnt;
    next_durCnt = durCnt;
    next_ivlCnt = ivlCnt;
    next_grnCnt = grnCnt;
    next_wlkCnt = wlkCnt;
    next_pedCnt = pedCnt;
    // only an inactive input clears the invalid mark
    if (!callRaw)
    begin
      next_presCnt = 14'h0000;
      next_invalid = 1'b0;
    end
    else
    begin
      if (tick && (presCnt != pts_pkg::DURATION_MAX))
      begin
        next_presCnt = presCnt + 14'h0001;
      end
      if ((cfg.maxCallPresence != 14'h0000) &&
          (presCnt >= cfg.maxCallPresence))
      begin
        next_invalid = 1'b1;
      end
    end
    // per-interval timers step on the tick
    if (tick)
    begin
      if (dlyCnt != 10'h000) next_dlyCnt = dlyCnt - 10'h001;
      if (durCnt != 14'h0000) next_durCnt = durCnt - 14'h0001;
      if (ivlCnt != 8'h00) next_ivlCnt = ivlCnt - 8'h01;
      if (grnCnt != 8'h00) next_grnCnt = grnCnt - 8'h01;
      if (wlkCnt != 8'h00) next_wlkCnt = wlkCnt - 8'h01;
      if (pedCnt != 8'h00) next_pedCnt = pedCnt - 8'h01;
    end
    unique case (state)
      pts_pkg::ST_IDLE:
      begin
        if (validCall)
        begin
          next_state = pts_pkg::ST_DELAY;
          next_dlyCnt = cfg.delay;
        end
      end
      pts_pkg::ST_DELAY:
      begin
        // lost call without hold drops the request
        if (!validCall && !cfg.callHold)
        begin
          next_state = pts_pkg::ST_IDLE;
        end
        // with hold the sequence runs even if the call left
        else if (dlyCnt == 10'h000)
        begin
          next_state = pts_pkg::ST_PROTECT;
          // minimum duration loads at delay end
          next_durCnt = cfg.minCallDuration;
          next_grnCnt = cfg.protectedGreenTime;
          next_wlkCnt = cfg.protectedWalkTime;
          next_pedCnt = cfg.protectedPedClearanceTime;
        end
      end
      pts_pkg::ST_PROTECT:
      begin
        if (grnOk && wlkOk && pedOk)
        begin
          next_state = pts_pkg::ST_TRACK;
          next_ivlCnt = cfg.trackGreenTime;
        end
      end
      pts_pkg::ST_TRACK:
      begin
        // track green timed from its own value
        if (ivlCnt == 8'h00)
        begin
          next_state = pts_pkg::ST_FIRST;
          next_ivlCnt = cfg.firstDwellTime;
        end
      end
      pts_pkg::ST_FIRST:
      begin
        // first dwell waits for time, duration and no call
        if (minsMet && !validCall)
        begin
          next_state = pts_pkg::ST_DWELL;
          next_ivlCnt = cfg.minDwellTime;
        end
      end
      pts_pkg::ST_DWELL:
      begin
        // dwell waits for time, duration and no call
        // past the minimums the real input decides
        // sequence over, back to normal operation
        if (minsMet && !validCall)
        begin
          next_state = pts_pkg::ST_IDLE;
        end
      end
    endcase
    next_ctl.active = (next_state != pts_pkg::ST_IDLE);
    next_ctl.greenEndOk = postDelay & grnOk;
    next_ctl.walkEndOk = postDelay & wlkOk;
    next_ctl.pedClearEndOk = postDelay & pedOk;
    next_ctl.ovlWalkToClear = postDelay & phase.walkActive &
                              phase.walkFromOverlap;
    next_ctl.trackGreen = (next_state == pts_pkg::ST_TRACK);
    next_ctl.firstDwell = (next_state == pts_pkg::ST_FIRST);
    next_ctl.dwell = (next_state == pts_pkg::ST_DWELL);
    // normally omitted phases allowed in preempt intervals
    next_ctl.omitOverride = next_ctl.trackGreen | next_ctl.firstDwell |
                            next_ctl.dwell;
    // serve only with a call or recall
    next_ctl.serveEnable = next_ctl.omitOverride & phase.vehCallPresent;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= pts_pkg::ST_IDLE;
      invalid <= 1'b0;
      presCnt <= 14'h0000;
      dlyCnt <= 10'h000;
      durCnt <= 14'h0000;
      ivlCnt <= 8'h00;
      grnCnt <= 8'h00;
      wlkCnt <= 8'h00;
      pedCnt <= 8'h00;
      ctl <= '0;
    end
    else
    begin
      state <= next_state;
      invalid <= next_invalid;
      presCnt <= next_presCnt;
      dlyCnt <= next_dlyCnt;
      durCnt <= next_durCnt;
      ivlCnt <= next_ivlCnt;
      grnCnt <= next_grnCnt;
      wlkCnt <= next_wlkCnt;
      pedCnt <= next_pedCnt;
      ctl <= next_ctl;
    end
  end

  // ********************************************************************
  // assertions
  // ********************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  drop_no_hold_a: assert property (
    (state == pts_pkg::ST_DELAY) && !validCall && !cfg.callHold
    |=> state == pts_pkg::ST_IDLE)
    else $error("call lost in delay did not drop request");
  hold_keeps_a: assert property (
    (state == pts_pkg::ST_DELAY) && cfg.callHold
    |=> state != pts_pkg::ST_IDLE)
    else $error("held call dropped during delay");
  duration_load_a: assert property (
    (state == pts_pkg::ST_DELAY) ##1 (state == pts_pkg::ST_PROTECT)
    |-> durCnt == $past(cfg.minCallDuration))
    else $error("minimum duration not loaded at delay end");
  dwell_exit_a: assert property (
    (state == pts_pkg::ST_DWELL) ##1 (state == pts_pkg::ST_IDLE)
    |-> $past(durCnt) == 14'h0000 && $past(ivlCnt) == 8'h00 &&
        !$past(validCall))
    else $error("dwell left before its minimums");
  first_exit_a: assert property (
    (state == pts_pkg::ST_FIRST) ##1 (state == pts_pkg::ST_DWELL)
    |-> $past(durCnt) == 14'h0000 && !$past(validCall) &&
        ivlCnt == $past(cfg.minDwellTime))
    else $error("first dwell left early");
  presence_off_a: assert property (
    $rose(invalid) |-> $past(cfg.maxCallPresence) != 14'h0000)
    else $error("zero presence limit invalidated a call");
  invalid_hold_a: assert property (
    invalid && callRaw |=> invalid)
    else $error("invalid call recovered while input active");
  green_end_a: assert property (
    ctl.greenEndOk |-> $past(grnCnt) == 8'h00 ||
      $past(phase.minGreenDone) || !$past(phase.greenActive))
    else $error("green released before protection");
  walk_end_a: assert property (
    ctl.walkEndOk |-> $past(wlkCnt) == 8'h00 || $past(phase.walkDone) ||
      $past(phase.walkFromOverlap) || !$past(phase.walkActive))
    else $error("walk released before protection");
  ped_end_a: assert property (
    ctl.pedClearEndOk |-> $past(pedCnt) == 8'h00 ||
      $past(phase.pedClearDone) || !$past(phase.pedClearActive))
    else $error("ped clearance released before protection");
  ovl_walk_a: assert property (
    postDelay && phase.walkActive && phase.walkFromOverlap
    |=> ctl.ovlWalkToClear && ctl.walkEndOk)
    else $error("overlap walk not sent to clearance");
  serve_call_a: assert property (
    ctl.serveEnable |-> $past(phase.vehCallPresent) && ctl.omitOverride)
    else $error("phase served without a call");
  tick_gap_a: assert property (
    tick |=> !tick [*2])
    else $error("seconds tick too frequent");
  bus_ack_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not a single cycle");

  full_seq_c: cover property (
    (state == pts_pkg::ST_DWELL) ##1 (state == pts_pkg::ST_IDLE));
  drop_c: cover property (
    (state == pts_pkg::ST_DELAY) ##1 (state == pts_pkg::ST_IDLE));
  invalid_c: cover property ($rose(invalid));
  track_c: cover property (
    (state == pts_pkg::ST_PROTECT) ##1 (state == pts_pkg::ST_TRACK));

endmodule : pts_sequencer

// ===== pts_pkg.sv
// shared constants, types and register map of the preempt timing sequencer
package pts_pkg;

  // ********************************************************************
  // register map (byte addresses, one aligned word each)
  // ********************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DELAY = 8'h04;
  localparam logic [7:0] ADDR_DURATION = 8'h08;
  localparam logic [7:0] ADDR_PRESENCE = 8'h0C;
  localparam logic [7:0] ADDR_PROTECT = 8'h10;
  localparam logic [7:0] ADDR_DWELL = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_TIMERS = 8'h1C;

  // ********************************************************************
  // field positions
  // ********************************************************************
  localparam int CTRL_HOLD_BIT = 0;
  localparam int CTRL_SEL_LSB = 4;
  localparam int PROT_WALK_LSB = 8;
  localparam int PROT_PED_LSB = 16;
  localparam int PROT_TRACK_LSB = 24;
  localparam int DWELL_FIRST_LSB = 8;
  localparam int STAT_RAW_BIT = 8;
  localparam int STAT_VALID_BIT = 9;
  localparam int STAT_INVALID_BIT = 10;
  localparam int TIMERS_IVL_LSB = 16;

  // ********************************************************************
  // sizes and reset values
  // ********************************************************************
  localparam int NUM_CHANNELS = 12;
  localparam logic [9:0] DELAY_MAX = 10'h258;
  localparam logic [13:0] DURATION_MAX = 14'h270F;
  localparam logic [7:0] DWELL_FLOOR = 8'h01;
  localparam logic [9:0] RST_DELAY = 10'h000;
  localparam logic [13:0] RST_DURATION = 14'h0000;
  localparam logic [13:0] RST_PRESENCE = 14'h0000;
  localparam logic [7:0] RST_TIME8 = 8'h00;
  localparam logic [7:0] RST_DWELL = 8'h01;

  // ********************************************************************
  // timing
  // ********************************************************************
  localparam int CLK_HZ = 20000000;
  localparam int TICK_PERIOD_SEC = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_PERIOD_SEC;

  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_DELAY   = 6'h02,
    ST_PROTECT = 6'h04,
    ST_TRACK   = 6'h08,
    ST_FIRST   = 6'h10,
    ST_DWELL   = 6'h20
  } pts_state_t;

  typedef struct packed {
    logic callHold;
    logic [3:0] chanSel;
    logic [9:0] delay;
    logic [13:0] minCallDuration;
    logic [13:0] maxCallPresence;
    logic [7:0] protectedGreenTime;
    logic [7:0] protectedWalkTime;
    logic [7:0] protectedPedClearanceTime;
    logic [7:0] trackGreenTime;
    logic [7:0] minDwellTime;
    logic [7:0] firstDwellTime;
  } pts_cfg_t;

  // status of the phase in service, from the phase timing logic
  typedef struct packed {
    logic greenActive;
    logic minGreenDone;
    logic walkActive;
    logic walkDone;
    logic walkFromOverlap;
    logic pedClearActive;
    logic pedClearDone;
    logic vehCallPresent;
  } pts_phase_t;

  // commands to the phase, walk and clearance logic
  typedef struct packed {
    logic greenEndOk;
    logic walkEndOk;
    logic pedClearEndOk;
    logic ovlWalkToClear;
    logic omitOverride;
    logic serveEnable;
    logic trackGreen;
    logic firstDwell;
    logic dwell;
    logic active;
  } pts_ctl_t;

endpackage : pts_pkg

// ===== pts_cabinet.sv
// cabinet side model: one ground-true preempt call line per channel
`timescale 1ns/1ps
module pts_cabinet (
  input wire logic clk,
  input wire logic [3:0] chan,
  input wire logic present,
  output logic [11:0] callInN
);
  // ********************
  // call lines
  // ********************
  // ground true call
  // idle lines sit at the pull-up level, never at a stale value
  always_ff @(posedge clk)
    callInN <= present ? ~(12'h001 << chan) : 12'hFFF;
endmodule : pts_cabinet

// ===== testbench.sv
// self-checking bench for the preempt timing sequencer
`timescale 1ns/1ps
module testbench;
  localparam int TK = 8;
  localparam logic [31:0] RST_EXP [8] = '{32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h101, 32'h1, 32'h0};
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [11:0] callInN;
  logic present = 1'h0;
  pts_pkg::pts_phase_t phase = '0;
  pts_pkg::pts_ctl_t ctl;
  logic [63:0] notes[$];
  logic [63:0] note;
  int err_count = 0;
  int samples_checked = 0;
  int seed = 32'h5B82C0B6;
  pts_sequencer #(.TICK_CYCLES(TK)) i_dut (.clk(clk), .resetn(resetn),
    .callInN(callInN), .phase(phase), .ctl(ctl), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));
  pts_cabinet i_cab (.clk(clk), .chan(4'h3), .present(present),
    .callInN(callInN));
  initial forever #25 clk = ~clk;
  // protect times of zero let any random phase status pass
  always @(posedge clk)
    phase <= 8'($random(seed));
  task automatic give_verdict();
    $display("checked %0d, errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic timedOut();
    err_count++;
    $display("Error at %0t: wait ran out", $time);
    give_verdict();
  endtask : timedOut
  // oldest read note against the data that came with the ack
  always @(posedge clk)
    if (wb_ack_o === 1'h1 && wb_we_i === 1'h0)
    begin
      note = notes.pop_front();
      check(wb_dat_o & note[31:0], note[63:32]);
    end
  task automatic wb(input logic we, input logic [7:0] adr,
      input logic [31:0] dat, input logic [63:0] exp);
    int n;
    if (!we)
      notes.push_back(exp);
    @(posedge clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'h1 && n < 20);
    if (wb_ack_o !== 1'h1)
      timedOut();
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask : wb
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb(1'h1, adr, dat, 64'h0);
  endtask : wr
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp,
      input logic [31:0] msk);
    wb(1'h0, adr, 32'h0, {exp, msk});
  endtask : rd
  task automatic waitFor(input int idx, input logic v, input int lim);
    int n;
    n = 0;
    while (ctl[idx] !== v)
    begin
      @(posedge clk);
      n++;
      if (n > lim)
        timedOut();
    end
  endtask : waitFor
  // ********************
  // stimulus
  // ********************
  initial
  begin
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    wr(8'h20, 32'hFFFFFFFF);
    wr(pts_pkg::ADDR_STATUS, 32'hFFFFFFFF);
    for (int i = 0; i < 8; i++)
      rd(i == 7 ? 8'h20 : 8'(i * 4), RST_EXP[i],
        i == 6 ? 32'h3F : 32'hFFFFFFFF);
    wr(pts_pkg::ADDR_DELAY, 32'h3FF);
    rd(pts_pkg::ADDR_DELAY, 32'h258, '1);
    wr(pts_pkg::ADDR_DURATION, 32'hFFFF);
    rd(pts_pkg::ADDR_DURATION, 32'h270F, '1);
    wr(pts_pkg::ADDR_DWELL, 32'h0);
    rd(pts_pkg::ADDR_DWELL, 32'h101, '1);
    wr(pts_pkg::ADDR_CTRL, 32'h30);
    wr(pts_pkg::ADDR_DELAY, 32'h3);
    wr(pts_pkg::ADDR_DURATION, 32'h0);
    present <= 1'h1;
    waitFor(0, 1'h1, 8);
    rd(pts_pkg::ADDR_STATUS, 32'h2, 32'h3F);
    present <= 1'h0;
    waitFor(0, 1'h0, 8);
    rd(pts_pkg::ADDR_STATUS, 32'h1, 32'h3F);
    wr(pts_pkg::ADDR_PRESENCE, 32'h2);
    wr(pts_pkg::ADDR_DELAY, 32'h258);
    present <= 1'h1;
    waitFor(0, 1'h1, 8);
    waitFor(0, 1'h0, 3 * TK);
    rd(pts_pkg::ADDR_STATUS, 32'h401, 32'h43F);
    repeat (3 * TK) @(posedge clk);
    rd(pts_pkg::ADDR_STATUS, 32'h401, 32'h43F);
    present <= 1'h0;
    repeat (5) @(posedge clk);
    rd(pts_pkg::ADDR_STATUS, 32'h1, 32'h43F);
    // no exit phases modelled, so a short min dwell is safe
    wr(pts_pkg::ADDR_CTRL, 32'h31);
    wr(pts_pkg::ADDR_DELAY, 32'h0);
    wr(pts_pkg::ADDR_PRESENCE, 32'h0);
    wr(pts_pkg::ADDR_DURATION, 32'h3);
    wr(pts_pkg::ADDR_PROTECT, 32'h0100_0002);
    present <= 1'h1;
    waitFor(3, 1'h1, 4 * TK);
    waitFor(2, 1'h1, 3 * TK);
    repeat (6 * TK) @(posedge clk);
    rd(pts_pkg::ADDR_STATUS, 32'h10, 32'h43F);
    rd(pts_pkg::ADDR_TIMERS, 32'h0, 32'hFF3FFF);
    present <= 1'h0;
    waitFor(1, 1'h1, 8);
    waitFor(0, 1'h0, 3 * TK);
    wr(pts_pkg::ADDR_DELAY, 32'h2);
    wr(pts_pkg::ADDR_DURATION, 32'h0);
    present <= 1'h1;
    waitFor(0, 1'h1, 8);
    present <= 1'h0;
    waitFor(3, 1'h1, 6 * TK);
    waitFor(0, 1'h0, 6 * TK);
    rd(pts_pkg::ADDR_STATUS, 32'h1, 32'h3F);
    give_verdict();
  end
endmodule : testbench
